// ---- logic/pim_cfg.svh ----
`ifndef PIM_CFG_SVH
`define PIM_CFG_SVH

// ----------------------------------------------------------------
// image layout
// ----------------------------------------------------------------
`define PIM_WORD_START    11'h000
`define PIM_PHYS_SPLIT    11'h100
`define PIM_PHYS_SHIFT    11'h100
`define PIM_LOGICAL_MAX   16'h03FC
`define PIM_PHYS1_HI      16'h00FF
`define PIM_VAR_LO        16'h0100
`define PIM_VAR_HI        16'h01FF
`define PIM_PHYS2_LO      16'h0200
`define PIM_PHYS2_HI      16'h04FB
`define PIM_WORD_BITS     9'h010
`define PIM_DIAG_BITS     9'h002
`define PIM_MOD_LAST      6'h3F

// ----------------------------------------------------------------
// non-volatile partition
// ----------------------------------------------------------------
`define PIM_FLAG_BASE       16'h0000
`define PIM_FLAG_SIZE_RST   16'h4000
`define PIM_RETAIN_BASE_RST 16'h4000
`define PIM_RETAIN_SIZE_RST 16'h4000
`define PIM_NV_TOP          17'h08000

// ----------------------------------------------------------------
// address string characters
// ----------------------------------------------------------------
`define PIM_CH_PCT    8'h25
`define PIM_CH_I      8'h49
`define PIM_CH_Q      8'h51
`define PIM_CH_M      8'h4D
`define PIM_CH_X      8'h58
`define PIM_CH_B      8'h42
`define PIM_CH_W      8'h57
`define PIM_CH_D      8'h44
`define PIM_CH_DOT    8'h2E
`define PIM_CH_ZERO   8'h30
`define PIM_CH_NINE   8'h39
`define PIM_BIT_MAX   5'h0F
`define PIM_ADDR_MAX  20'h0FFFF

`endif

// ---- logic/pim_pkg.sv ----
package pim_pkg;

    // module classes reported by the module table
    typedef enum logic [3:0] {
        PIM_K_END,
        PIM_K_AIN,
        PIM_K_AOUT,
        PIM_K_CPLX_IN,
        PIM_K_CPLX_OUT,
        PIM_K_DIN,
        PIM_K_DOUT,
        PIM_K_DOUT_DIAG,
        PIM_K_SUPPLY,
        PIM_K_RELAY
    } pim_kind_t;

    typedef enum logic [1:0] {
        PIM_A_INPUT,
        PIM_A_OUTPUT,
        PIM_A_FLAG
    } pim_area_t;

    typedef enum logic [1:0] {
        PIM_W_BIT,
        PIM_W_BYTE,
        PIM_W_WORD,
        PIM_W_DWORD
    } pim_width_t;

    typedef enum {
        PIM_S_IDLE,
        PIM_S_WORDS,
        PIM_S_BITS,
        PIM_S_DONE
    } pim_map_state_t;

    typedef enum {
        PIM_D_PCT,
        PIM_D_AREA,
        PIM_D_WIDTH,
        PIM_D_NUM,
        PIM_D_BIT,
        PIM_D_FAIL
    } pim_dec_state_t;

endpackage : pim_pkg

// ---- logic/pim_addr_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pim_cfg.svh"

module pim_addr_decode (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              NRST,
    // character stream
    input  wire logic              CH_VALID,
    input  wire logic [7:0]        CH_DATA,
    input  wire logic              CH_LAST,
    // decoded address
    output logic                   DEC_VALID,
    output logic                   DEC_ERROR,
    output pim_pkg::pim_area_t     DEC_AREA,
    output pim_pkg::pim_width_t    DEC_WIDTH,
    output logic [15:0]            DEC_WORD,
    output logic [3:0]             DEC_BIT
);
    import pim_pkg::*;

    pim_dec_state_t state,     next_state;
    pim_area_t      area,      next_area;
    pim_width_t     width,     next_width;
    logic [15:0]    num,       next_num;
    logic [4:0]     bitn,      next_bitn;
    logic           seen,      next_seen;
    logic           valid,     next_valid;
    logic           err,       next_err;
    logic           is_digit;
    logic [3:0]     digit;
    logic [19:0]    num_x10;
    logic [7:0]     bit_x10;

    assign is_digit = (CH_DATA >= `PIM_CH_ZERO) && (CH_DATA <= `PIM_CH_NINE);
    assign digit    = 4'(CH_DATA - `PIM_CH_ZERO);
    assign num_x10  = {num, 3'h0} + {3'h0, num, 1'h0} + {16'h0, digit};
    assign bit_x10  = {bitn, 3'h0} + {2'h0, bitn, 1'h0} + {4'h0, digit};

    // ----------------------------------------------------------------
    // parser: percent, area, optional width, number, optional bit
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_area  = area;
        next_width = width;
        next_num   = num;
        next_bitn  = bitn;
        next_seen  = seen;
        next_valid = 1'b0;
        next_err   = err;
        if (CH_VALID) begin
            case (state)
                PIM_D_PCT: begin
                    next_num   = 16'h0000;
                    next_bitn  = 5'h00;
                    next_seen  = 1'b0;
                    next_width = PIM_W_BIT;
                    next_state = (CH_DATA == `PIM_CH_PCT) ? PIM_D_AREA : PIM_D_FAIL;
                end
                PIM_D_AREA: begin
                    next_state = PIM_D_WIDTH;
                    if (CH_DATA == `PIM_CH_I)      next_area = PIM_A_INPUT;
                    else if (CH_DATA == `PIM_CH_Q) next_area = PIM_A_OUTPUT;
                    else if (CH_DATA == `PIM_CH_M) next_area = PIM_A_FLAG;
                    else                           next_state = PIM_D_FAIL;
                end
                PIM_D_WIDTH: begin
                    next_state = PIM_D_NUM;
                    if (CH_DATA == `PIM_CH_X)      next_width = PIM_W_BIT;
                    else if (CH_DATA == `PIM_CH_B) next_width = PIM_W_BYTE;
                    else if (CH_DATA == `PIM_CH_W) next_width = PIM_W_WORD;
                    else if (CH_DATA == `PIM_CH_D) next_width = PIM_W_DWORD;
                    else if (is_digit) begin
                        next_width = PIM_W_BIT; // missing letter means bit
                        next_num   = {12'h000, digit};
                        next_seen  = 1'b1;
                    end else begin
                        next_state = PIM_D_FAIL;
                    end
                end
                PIM_D_NUM: begin
                    if (is_digit && num_x10 <= `PIM_ADDR_MAX) begin
                        next_num  = num_x10[15:0];
                        next_seen = 1'b1;
                    end else if (CH_DATA == `PIM_CH_DOT && seen && width == PIM_W_BIT) begin
                        next_state = PIM_D_BIT; // word.bit form
                        next_seen  = 1'b0;
                    end else begin
                        next_state = PIM_D_FAIL;
                    end
                end
                PIM_D_BIT: begin
                    if (is_digit && bit_x10 <= {3'h0, `PIM_BIT_MAX}) begin
                        next_bitn = bit_x10[4:0];
                        next_seen = 1'b1;
                    end else begin
                        next_state = PIM_D_FAIL;
                    end
                end
                PIM_D_FAIL: next_state = PIM_D_FAIL;
                default:    next_state = PIM_D_FAIL;
            endcase
            if (CH_LAST) begin
                next_valid = 1'b1;
                next_err   = !((next_state == PIM_D_NUM || next_state == PIM_D_BIT) && next_seen);
                next_state = PIM_D_PCT;
            end
        end
    end

    // ----------------------------------------------------------------
    // parser state
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state <= PIM_D_PCT;
            area  <= PIM_A_INPUT;
            width <= PIM_W_BIT;
            num   <= 16'h0000;
            bitn  <= 5'h00;
            seen  <= 1'b0;
            valid <= 1'b0;
            err   <= 1'b0;
        end else begin
            state <= next_state;
            area  <= next_area;
            width <= next_width;
            num   <= next_num;
            bitn  <= next_bitn;
            seen  <= next_seen;
            valid <= next_valid;
            err   <= next_err;
        end
    end

    assign DEC_VALID = valid;
    assign DEC_ERROR = err;
    assign DEC_AREA  = area;
    assign DEC_WIDTH = width;
    assign DEC_WORD  = num;
    assign DEC_BIT   = bitn[3:0];

endmodule : pim_addr_decode
`default_nettype wire

// ---- logic/pim_mapper.sv ----
// Functional notes
// - auto map modules 0 to 62 before exchange
// - multi-byte modules first from word 0
// - then bit modules packed bit by bit
// - end module ends the scan, gets no address
// - separate input and output counters
// - analog: one 16-bit word per channel
// - bit modules start next word, bit 0
// - bit address is word dot bit
// - diag outputs two bits per channel
// - fieldbus input variables: fieldbus rw, plc read
// - plc output variables: plc rw, fieldbus read
// - flag start fixed, others configurable
// - defaults flag 16#4000 then retain 16#4000
// - decode percent, area letter, width, number
// - width X B W D, missing means bit
// - rebuild whole image on configuration change
// - physical words 0-255 then 512-1275
`timescale 1ns/1ps
`default_nettype none
`include "pim_cfg.svh"

module pim_mapper (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              NRST,
    // module table
    input  wire logic              CFG_CHANGE,
    output logic [5:0]             MOD_SEL,
    input  wire pim_pkg::pim_kind_t MOD_KIND,
    input  wire logic [4:0]        MOD_CHANNELS,
    // allocation results
    output logic                   RES_VALID,
    output logic [5:0]             RES_INDEX,
    output logic                   RES_OUTPUT,
    output logic                   RES_BITWISE,
    output logic [10:0]            RES_WORD,
    output logic [3:0]             RES_BIT,
    output logic [8:0]             RES_BITS,
    output logic                   MAP_READY,
    output logic                   MAP_OVERFLOW,
    // access check
    input  wire logic              ACC_REQ,
    input  wire logic              ACC_PLC_SIDE,
    input  wire logic              ACC_WRITE,
    input  wire pim_pkg::pim_area_t ACC_AREA,
    input  wire logic [15:0]       ACC_WORD,
    output logic                   ACC_DONE,
    output logic                   ACC_GRANT,
    // non-volatile partition
    input  wire logic              NV_LOAD,
    input  wire logic [15:0]       NV_FLAG_SIZE_IN,
    input  wire logic [15:0]       NV_RETAIN_BASE_IN,
    input  wire logic [15:0]       NV_RETAIN_SIZE_IN,
    output logic [15:0]            NV_FLAG_BASE,
    output logic [15:0]            NV_FLAG_SIZE,
    output logic [15:0]            NV_RETAIN_BASE,
    output logic [15:0]            NV_RETAIN_SIZE,
    output logic                   NV_OVERLAP,
    // address string decoder
    input  wire logic              CH_VALID,
    input  wire logic [7:0]        CH_DATA,
    input  wire logic              CH_LAST,
    output logic                   DEC_VALID,
    output logic                   DEC_ERROR,
    output pim_pkg::pim_area_t     DEC_AREA,
    output pim_pkg::pim_width_t    DEC_WIDTH,
    output logic [15:0]            DEC_WORD,
    output logic [3:0]             DEC_BIT
);
    import pim_pkg::*;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic logic is_multi(input pim_kind_t k);
        is_multi = (k == PIM_K_AIN) || (k == PIM_K_AOUT) ||
                   (k == PIM_K_CPLX_IN) || (k == PIM_K_CPLX_OUT);
    endfunction : is_multi

    function automatic logic is_out(input pim_kind_t k);
        is_out = (k == PIM_K_AOUT) || (k == PIM_K_CPLX_OUT) || (k == PIM_K_DOUT) ||
                 (k == PIM_K_DOUT_DIAG) || (k == PIM_K_RELAY);
    endfunction : is_out

    // logical image word to physical word, skipping the variable area
    function automatic logic [10:0] phys_word(input logic [10:0] w);
        phys_word = (w < `PIM_PHYS_SPLIT) ? w : w + `PIM_PHYS_SHIFT;
    endfunction : phys_word

    // ----------------------------------------------------------------
    // allocation state
    // ----------------------------------------------------------------
    pim_map_state_t state,    next_state;
    logic [5:0]     sel,      next_sel;
    logic [10:0]    in_w,     next_in_w;
    logic [10:0]    out_w,    next_out_w;
    logic [14:0]    in_b,     next_in_b;
    logic [14:0]    out_b,    next_out_b;
    logic           ready,    next_ready;
    logic           ovf,      next_ovf;
    logic           r_valid,  next_r_valid;
    logic [5:0]     r_index,  next_r_index;
    logic           r_out,    next_r_out;
    logic           r_bitw,   next_r_bitw;
    logic [10:0]    r_word,   next_r_word;
    logic [3:0]     r_bit,    next_r_bit;
    logic [8:0]     r_bits,   next_r_bits;

    logic           mod_out;
    logic           at_end;
    logic [10:0]    cur_w;
    logic [14:0]    cur_b;
    logic [15:0]    w_sum;
    logic [15:0]    b_sum;
    logic [8:0]     word_span;
    logic [8:0]     bit_span;

    assign mod_out   = is_out(MOD_KIND);
    assign at_end    = (MOD_KIND == PIM_K_END);
    assign cur_w     = mod_out ? out_w : in_w;
    assign cur_b     = mod_out ? out_b : in_b;
    assign w_sum     = {5'h00, cur_w} + {11'h000, MOD_CHANNELS};
    assign word_span = {4'h0, MOD_CHANNELS} * `PIM_WORD_BITS;
    assign bit_span  = (MOD_KIND == PIM_K_DOUT_DIAG) ?
                       {4'h0, MOD_CHANNELS} * `PIM_DIAG_BITS : {4'h0, MOD_CHANNELS};
    assign b_sum     = {1'h0, cur_b} + {7'h00, bit_span};

    // ----------------------------------------------------------------
    // scan: word pass, then bit pass, then hold
    // ----------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_sel     = sel;
        next_in_w    = in_w;
        next_out_w   = out_w;
        next_in_b    = in_b;
        next_out_b   = out_b;
        next_ready   = ready;
        next_ovf     = ovf;
        next_r_valid = 1'b0;
        next_r_index = r_index;
        next_r_out   = r_out;
        next_r_bitw  = r_bitw;
        next_r_word  = r_word;
        next_r_bit   = r_bit;
        next_r_bits  = r_bits;
        case (state)
            PIM_S_IDLE: begin
                next_sel   = 6'h00;
                next_in_w  = `PIM_WORD_START;
                next_out_w = `PIM_WORD_START;
                next_ready = 1'b0;
                next_ovf   = 1'b0;
                next_state = PIM_S_WORDS;
            end
            PIM_S_WORDS: begin
                if (at_end || sel == `PIM_MOD_LAST) begin
                    next_sel   = 6'h00;
                    next_in_b  = {in_w, 4'h0};
                    next_out_b = {out_w, 4'h0};
                    next_state = PIM_S_BITS;
                end else begin
                    next_sel = sel + 6'h01;
                    if (is_multi(MOD_KIND)) begin
                        next_r_valid = 1'b1;
                        next_r_index = sel;
                        next_r_out   = mod_out;
                        next_r_bitw  = 1'b0;
                        next_r_word  = phys_word(cur_w);
                        next_r_bit   = 4'h0;
                        next_r_bits  = word_span;
                        if (w_sum > `PIM_LOGICAL_MAX) next_ovf = 1'b1;
                        if (mod_out) next_out_w = w_sum[10:0];
                        else         next_in_w  = w_sum[10:0];
                    end
                end
            end
            PIM_S_BITS: begin
                if (at_end || sel == `PIM_MOD_LAST) begin
                    next_state = PIM_S_DONE;
                    next_ready = 1'b1;
                end else begin
                    next_sel = sel + 6'h01;
                    if (!is_multi(MOD_KIND)) begin
                        next_r_valid = 1'b1;
                        next_r_index = sel;
                        next_r_out   = mod_out;
                        next_r_bitw  = 1'b1;
                        next_r_word  = phys_word(cur_b[14:4]);
                        next_r_bit   = cur_b[3:0];
                        next_r_bits  = bit_span;
                        if (b_sum > (`PIM_LOGICAL_MAX << 4)) next_ovf = 1'b1;
                        if (mod_out) next_out_b = b_sum[14:0];
                        else         next_in_b  = b_sum[14:0];
                    end
                end
            end
            PIM_S_DONE: next_state = PIM_S_DONE;
            default:    next_state = PIM_S_IDLE;
        endcase
        if (CFG_CHANGE) begin
            next_state   = PIM_S_IDLE;
            next_ready   = 1'b0;
            next_r_valid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // allocation registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state   <= PIM_S_IDLE;
            sel     <= 6'h00;
            in_w    <= 11'h000;
            out_w   <= 11'h000;
            in_b    <= 15'h0000;
            out_b   <= 15'h0000;
            ready   <= 1'b0;
            ovf     <= 1'b0;
            r_valid <= 1'b0;
            r_index <= 6'h00;
            r_out   <= 1'b0;
            r_bitw  <= 1'b0;
            r_word  <= 11'h000;
            r_bit   <= 4'h0;
            r_bits  <= 9'h000;
        end else begin
            state   <= next_state;
            sel     <= next_sel;
            in_w    <= next_in_w;
            out_w   <= next_out_w;
            in_b    <= next_in_b;
            out_b   <= next_out_b;
            ready   <= next_ready;
            ovf     <= next_ovf;
            r_valid <= next_r_valid;
            r_index <= next_r_index;
            r_out   <= next_r_out;
            r_bitw  <= next_r_bitw;
            r_word  <= next_r_word;
            r_bit   <= next_r_bit;
            r_bits  <= next_r_bits;
        end
    end

    assign MOD_SEL      = sel;
    assign RES_VALID    = r_valid;
    assign RES_INDEX    = r_index;
    assign RES_OUTPUT   = r_out;
    assign RES_BITWISE  = r_bitw;
    assign RES_WORD     = r_word;
    assign RES_BIT      = r_bit;
    assign RES_BITS     = r_bits;
    assign MAP_READY    = ready;
    assign MAP_OVERFLOW = ovf;

    // ----------------------------------------------------------------
    // non-volatile partition
    // ----------------------------------------------------------------
    logic [15:0] flag_size,   next_flag_size;
    logic [15:0] ret_base,    next_ret_base;
    logic [15:0] ret_size,    next_ret_size;

    // flag base is a constant; sizes and retain base reload on strobe
    always_comb begin
        next_flag_size = flag_size;
        next_ret_base  = ret_base;
        next_ret_size  = ret_size;
        if (NV_LOAD) begin
            next_flag_size = NV_FLAG_SIZE_IN;
            next_ret_base  = NV_RETAIN_BASE_IN;
            next_ret_size  = NV_RETAIN_SIZE_IN;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            flag_size <= `PIM_FLAG_SIZE_RST;
            ret_base  <= `PIM_RETAIN_BASE_RST;
            ret_size  <= `PIM_RETAIN_SIZE_RST;
        end else begin
            flag_size <= next_flag_size;
            ret_base  <= next_ret_base;
            ret_size  <= next_ret_size;
        end
    end

    assign NV_FLAG_BASE   = `PIM_FLAG_BASE;
    assign NV_FLAG_SIZE   = flag_size;
    assign NV_RETAIN_BASE = ret_base;
    assign NV_RETAIN_SIZE = ret_size;
    // warn when the two areas collide or run past the memory top
    assign NV_OVERLAP = ({1'b0, ret_base} < {1'b0, `PIM_FLAG_BASE} + {1'b0, flag_size}) ||
                        ({1'b0, ret_base} + {1'b0, ret_size} > `PIM_NV_TOP);

    // ----------------------------------------------------------------
    // access rights per address area
    // ----------------------------------------------------------------
    logic in_phys;
    logic in_var;
    logic in_flag;
    logic grant_now;
    logic done,  next_done;
    logic grant, next_grant;

    assign in_phys = (ACC_WORD <= `PIM_PHYS1_HI) ||
                     (ACC_WORD >= `PIM_PHYS2_LO && ACC_WORD <= `PIM_PHYS2_HI);
    assign in_var  = (ACC_WORD >= `PIM_VAR_LO) && (ACC_WORD <= `PIM_VAR_HI);
    assign in_flag = {ACC_WORD, 1'b0} < {1'b0, `PIM_FLAG_BASE} + {1'b0, flag_size};

    always_comb begin
        grant_now = 1'b0;
        case (ACC_AREA)
            PIM_A_INPUT:  grant_now = (in_phys && !ACC_WRITE) ||
                                      (in_var && (!ACC_PLC_SIDE || !ACC_WRITE));
            PIM_A_OUTPUT: grant_now = in_phys ||
                                      (in_var && (ACC_PLC_SIDE || !ACC_WRITE));
            PIM_A_FLAG:   grant_now = in_flag;
            default:      grant_now = 1'b0;
        endcase
        next_done  = ACC_REQ;
        next_grant = ACC_REQ && ready && grant_now; // no exchange before mapping
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            done  <= 1'b0;
            grant <= 1'b0;
        end else begin
            done  <= next_done;
            grant <= next_grant;
        end
    end

    assign ACC_DONE  = done;
    assign ACC_GRANT = grant;

    // ----------------------------------------------------------------
    // absolute address string decoder
    // ----------------------------------------------------------------
    pim_addr_decode u_decode (
        .CLOCK     (CLOCK),
        .NRST      (NRST),
        .CH_VALID  (CH_VALID),
        .CH_DATA   (CH_DATA),
        .CH_LAST   (CH_LAST),
        .DEC_VALID (DEC_VALID),
        .DEC_ERROR (DEC_ERROR),
        .DEC_AREA  (DEC_AREA),
        .DEC_WIDTH (DEC_WIDTH),
        .DEC_WORD  (DEC_WORD),
        .DEC_BIT   (DEC_BIT)
    );

endmodule : pim_mapper
`default_nettype wire

// ---- verification/pim_mapper_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pim_mapper_chk import pim_pkg::*; (
    input wire logic        CLOCK, NRST, CFG_CHANGE, MAP_READY, RES_VALID, RES_BITWISE,
    input wire logic        ACC_REQ, ACC_PLC_SIDE, ACC_WRITE, ACC_DONE, ACC_GRANT, NV_LOAD,
    input wire logic [10:0] RES_WORD,
    input wire logic [3:0]  RES_BIT,
    input wire pim_area_t   ACC_AREA,
    input wire logic [15:0] ACC_WORD, NV_FLAG_BASE, NV_FLAG_SIZE, NV_FLAG_SIZE_IN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // write into the shared variable window
    wire logic var_wr = ACC_REQ && ACC_WRITE && ACC_WORD inside {[16'h0100:16'h01FF]};
    AST_ACC_ANSWER: assert property (ACC_REQ |=> ACC_DONE)
        else $error("access answer missing");
    AST_GRANT_READY: assert property (ACC_GRANT |-> $past(MAP_READY))
        else $error("grant before image ready");
    AST_IN_VAR_RO: assert property (var_wr && ACC_PLC_SIDE && ACC_AREA == PIM_A_INPUT |=> !ACC_GRANT)
        else $error("plc wrote input variables");
    AST_OUT_VAR_RO: assert property (var_wr && !ACC_PLC_SIDE && ACC_AREA == PIM_A_OUTPUT |=> !ACC_GRANT)
        else $error("fieldbus wrote output variables");
    AST_READ_OK: assert property (ACC_REQ && !ACC_WRITE && MAP_READY && !CFG_CHANGE && ACC_AREA != PIM_A_FLAG
        && ACC_WORD < 16'h04FC |=> ACC_GRANT)
        else $error("image read refused");
    AST_RES_PHYS: assert property (RES_VALID |-> !(RES_WORD inside {[11'h100:11'h1FF]}))
        else $error("module placed in variable window");
    AST_WORD_BIT0: assert property (RES_VALID && !RES_BITWISE |-> RES_BIT == 4'h0)
        else $error("word module not on bit 0");
    AST_FLAG_BASE: assert property (NV_FLAG_BASE == 16'h0000)
        else $error("flag base moved");
    AST_NV_LOAD: assert property (NV_LOAD |=> NV_FLAG_SIZE == $past(NV_FLAG_SIZE_IN))
        else $error("flag size not loaded");
    AST_CFG_REBUILD: assert property (CFG_CHANGE |=> !MAP_READY)
        else $error("image kept after change");
    COV_BITS: cover property (RES_VALID && RES_BITWISE);
    COV_GRANT: cover property (ACC_GRANT);
    COV_READY: cover property ($rose(MAP_READY));
endmodule : pim_mapper_chk
bind pim_mapper pim_mapper_chk u_chk (.*);
`default_nettype wire

// ---- verification/pim_modtab.sv ----
`timescale 1ns/1ps
`default_nettype none
module pim_modtab import pim_pkg::*; (
    input wire logic [5:0] MOD_SEL,
    input wire logic       ALT,
    output pim_kind_t      MOD_KIND,
    output logic [4:0]     MOD_CHANNELS
);
    // table: analog in, digital in, analog out, digital out, then end; with ALT one diag output, then end
    always_comb begin
        MOD_KIND = PIM_K_END;
        MOD_CHANNELS = ALT ? 5'h03 : 5'h02;
        if (ALT && MOD_SEL == 6'h00) MOD_KIND = PIM_K_DOUT_DIAG;
        else if (!ALT && MOD_SEL < 6'h04) MOD_KIND = pim_kind_t'(MOD_SEL[1] ? (MOD_SEL[0] ? 6 : 2) : (MOD_SEL[0] ? 5 : 1));
    end
endmodule : pim_modtab
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb import pim_pkg::*;;
    logic CLOCK = 0, NRST = 0, CFG_CHANGE = 0, ACC_REQ = 0, ACC_PLC_SIDE = 0, ACC_WRITE = 0, NV_LOAD = 0;
    logic CH_VALID = 0, CH_LAST = 0, ALT = 0, RES_VALID, RES_OUTPUT, RES_BITWISE, MAP_READY, MAP_OVERFLOW;
    logic ACC_DONE, ACC_GRANT, NV_OVERLAP, DEC_VALID, DEC_ERROR;
    logic [15:0] ACC_WORD = '0, NV_FLAG_SIZE_IN = '0, NV_RETAIN_BASE_IN = '0, NV_RETAIN_SIZE_IN = '0;
    logic [15:0] NV_FLAG_BASE, NV_FLAG_SIZE, NV_RETAIN_BASE, NV_RETAIN_SIZE, DEC_WORD;
    logic [7:0] CH_DATA = '0;
    logic [5:0] MOD_SEL, RES_INDEX;
    logic [10:0] RES_WORD;
    logic [8:0] RES_BITS;
    logic [4:0] MOD_CHANNELS;
    logic [3:0] RES_BIT, DEC_BIT;
    pim_area_t ACC_AREA = PIM_A_INPUT, DEC_AREA;
    pim_width_t DEC_WIDTH;
    pim_kind_t MOD_KIND;
    int miscompares = 0, n_compared = 0, cyc = 0;
    pim_mapper u_dut (.*);
    pim_modtab u_tab (.*);
    always #2 CLOCK = ~CLOCK;
    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic step;
        @(posedge CLOCK) #1;
    endtask : step
    task automatic res(input logic [5:0] i, input logic o, b, input logic [10:0] w, input logic [8:0] n);
        do step; while (RES_VALID !== 1'b1);
        chk("res", {RES_INDEX, RES_OUTPUT, RES_BITWISE, RES_WORD, RES_BIT, RES_BITS}, {i, o, b, w, 4'h0, n});
    endtask : res
    task automatic acc(input logic p, w, input pim_area_t a, input logic [15:0] wd, input logic g);
        {ACC_PLC_SIDE, ACC_WRITE, ACC_WORD, ACC_REQ} = {p, w, wd, 1'b1};
        ACC_AREA = a;
        step;
        chk("acc", {ACC_DONE, ACC_GRANT}, {1'b1, g});
        ACC_REQ = 1'b0;
        step;
    endtask : acc
    task automatic dec(input string s, input logic [25:0] e);
        foreach (s[i]) begin
            {CH_VALID, CH_DATA, CH_LAST} = {1'b1, s[i], i == s.len() - 1};
            step;
        end
        chk(s, {DEC_VALID, DEC_ERROR, DEC_AREA, DEC_WIDTH, DEC_WORD, DEC_BIT}, e);
        {CH_VALID, CH_LAST} = 2'h0;
        step;
    endtask : dec
    task automatic report_and_stop;
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    // hang guard
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop;
        end
    end
    initial begin
        repeat (10) step;
        NRST = 1'b1;
        chk("nv", {NV_FLAG_SIZE, NV_RETAIN_BASE}, 32'h40004000);
        res(6'h00, 0, 0, 11'h000, 9'h020);
        res(6'h02, 1, 0, 11'h000, 9'h020);
        res(6'h01, 0, 1, 11'h002, 9'h002);
        res(6'h03, 1, 1, 11'h002, 9'h002);
        repeat (2) step;
        chk("ready", {MAP_OVERFLOW, MAP_READY}, 2'h1);
        acc(1, 1, PIM_A_INPUT, 16'h012C, 0);
        acc(0, 1, PIM_A_INPUT, 16'h012C, 1);
        acc(1, 0, PIM_A_INPUT, 16'h01FF, 1);
        acc(0, 1, PIM_A_OUTPUT, 16'h0100, 0);
        acc(1, 1, PIM_A_OUTPUT, 16'h0100, 1);
        acc(0, 0, PIM_A_INPUT, 16'h04FB, 1);
        acc(0, 1, PIM_A_INPUT, 16'h0200, 0);
        acc(1, 1, PIM_A_FLAG, 16'h1FFF, 1);
        acc(1, 1, PIM_A_FLAG, 16'h2000, 0);
        {NV_LOAD, NV_FLAG_SIZE_IN, NV_RETAIN_BASE_IN, NV_RETAIN_SIZE_IN} = {1'b1, 48'h200030001000};
        step;
        NV_LOAD = 1'b0;
        chk("nv", {NV_FLAG_BASE, NV_RETAIN_BASE}, 32'h00003000);
        dec("%QW27", {2'h2, PIM_A_OUTPUT, PIM_W_WORD, 16'h001B, 4'h0});
        dec("%IX1.9", {2'h2, PIM_A_INPUT, PIM_W_BIT, 16'h0001, 4'h9});
        dec("%I14.3", {2'h2, PIM_A_INPUT, PIM_W_BIT, 16'h000E, 4'h3});
        dec("%MB22", {2'h2, PIM_A_FLAG, PIM_W_BYTE, 16'h0016, 4'h0});
        dec("%ID7", {2'h2, PIM_A_INPUT, PIM_W_DWORD, 16'h0007, 4'h0});
        {ALT, CFG_CHANGE} = 2'h3;
        step;
        CFG_CHANGE = 1'b0;
        step;
        chk("ready", MAP_READY, 0);
        res(6'h00, 1, 1, 11'h000, 9'h006);
        report_and_stop;
    end
endmodule : tb
`default_nettype wire
